// File: ocp_defines.svh
// Register offsets, field positions, reset values and codes for the output compare channel
`ifndef OCP_DEFINES_SVH
`define OCP_DEFINES_SVH

`define OCP_ADDR_CTRL1 3'h0
`define OCP_ADDR_CTRL2 3'h1
`define OCP_ADDR_PRI 3'h2
`define OCP_ADDR_SEC 3'h3
`define OCP_ADDR_PER 3'h4
`define OCP_ADDR_CNT 3'h5
`define OCP_ADDR_STAT 3'h6

`define OCP_CTRL1_RST 16'h0000
`define OCP_CTRL2_RST 16'h000C
`define OCP_CTRL1_WMASK 16'h1F8F
`define OCP_CTRL2_WMASK 16'h01BF

`define OCP_MODE_LSB 0
`define OCP_TRGCLR_BIT 3
`define OCP_FLTST_LSB 4
`define OCP_FLTEN_LSB 7
`define OCP_TBSEL_LSB 10
`define OCP_SYNC_LSB 0
`define OCP_TRIS_BIT 5
`define OCP_TRGST_BIT 6
`define OCP_TRIG_BIT 7
`define OCP_CASC_BIT 8
`define OCP_IRQ_BIT 0

`define OCP_MODE_OFF 3'h0
`define OCP_MODE_SS_RISE 3'h1
`define OCP_MODE_SS_FALL 3'h2
`define OCP_MODE_TOGGLE 3'h3
`define OCP_MODE_DBL_SS 3'h4
`define OCP_MODE_DBL_CONT 3'h5
`define OCP_MODE_PWM_EDGE 3'h6
`define OCP_MODE_PWM_CTR 3'h7

`define OCP_SYNC_FREE 5'h00
`define OCP_SYNC_SELF 5'h1F
`define OCP_TB_CORE 3'h7
`define OCP_TB_TIMER_MAX 3'h4
`define OCP_CNT_MAX 16'hFFFF

`endif

// File: ocp_pkg.sv
// Types shared by the output compare channel files
package ocp_pkg;
	typedef enum logic [1:0] {OCP_ST_IDLE, OCP_ST_ARMED, OCP_ST_ACTIVE, OCP_ST_SPENT} ocp_phase_type;
	typedef logic [2:0] ocp_mode_type;
endpackage

// File: ocp_counter.sv
// Channel counter with step, increment qualifier and synchronous clear
`timescale 1ns/1ps
module ocp_counter #(
	parameter int W = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic clr_i,
	input wire logic inc_i,
	output logic [W-1:0] count_o
);
	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	always_comb
	begin
		nxt_count = count_ff;
		if (clr_i)
			nxt_count = '0;
		else if (inc_i)
			// Wraps from all ones to zero by plain overflow
			nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_ff <= '0;
		else if (ce_i)
			count_ff <= nxt_count;
	end

	assign count_o = count_ff;
endmodule

// File: ocp_channel.sv
// Output compare and PWM channel with its own counter and register port
`timescale 1ns/1ps
`include "ocp_defines.svh"

module ocp_channel #(
	parameter int W = 16,
	parameter bit CASC_HIGH = 1'b0
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic [4:0] timer_tick_i,
	input wire logic [31:0] sync_event_i,
	input wire logic [2:0] fault_i,
	input wire logic casc_step_i,
	input wire logic casc_carry_i,
	input wire logic casc_pri_match_i,
	input wire logic casc_sec_match_i,
	input wire logic casc_per_match_i,
	output logic casc_step_o,
	output logic casc_carry_o,
	output logic casc_pri_match_o,
	output logic casc_sec_match_o,
	output logic casc_per_match_o,
	output logic waveform_output_pin_o,
	output logic waveform_oe_n_o,
	output logic compare_irq_flag_o
);
	logic [15:0] channel_control_one_ff;
	logic [15:0] channel_control_two_ff;
	logic [W-1:0] primary_compare_reg_ff;
	logic [W-1:0] secondary_compare_reg_ff;
	logic [W-1:0] timer_period_reg_ff;
	logic [W-1:0] pri_buf_ff;
	logic [W-1:0] sec_buf_ff;
	logic trigger_status_ff;
	logic nxt_trigger_status;
	logic compare_irq_flag_ff;
	logic [2:0] fault_stat_ff;
	logic [2:0] nxt_fault_stat;
	logic out_ff;
	logic nxt_out;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	ocp_pkg::ocp_phase_type phase_ff;
	ocp_pkg::ocp_phase_type nxt_phase;
	ocp_pkg::ocp_mode_type output_mode_select;
	logic [4:0] sync_source_select;
	logic [2:0] timebase_select;
	logic [2:0] fault_input_enables;
	logic trigger_mode_select;
	logic trigger_status_clear_mode;
	logic cascade_enable;
	logic output_tristate;
	logic [W-1:0] channel_counter;
	logic is_pwm;
	logic is_high;
	logic own_step;
	logic step;
	logic run;
	logic sync_ev;
	logic cnt_clr;
	logic cnt_inc;
	logic pri_hit;
	logic sec_hit;
	logic per_hit;
	logic irq_ev;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic pwm_level;

	// Picks the counting tick; timers give their prescaler tick
	function automatic logic tb_tick(input logic [2:0] sel, input logic [4:0] ticks);
		logic t;
		t = 1'b0;
		if (sel == `OCP_TB_CORE)
			t = 1'b1;
		else if (sel <= `OCP_TB_TIMER_MAX)
			t = ticks[sel];
		return t;
	endfunction

	// A match in a cascaded pair needs both halves to agree
	function automatic logic pair_match(input logic own, input logic partner, input logic casc);
		return own & (!casc | partner);
	endfunction

	assign output_mode_select = channel_control_one_ff[`OCP_MODE_LSB +: 3];
	assign trigger_status_clear_mode = channel_control_one_ff[`OCP_TRGCLR_BIT];
	assign fault_input_enables = channel_control_one_ff[`OCP_FLTEN_LSB +: 3];
	assign timebase_select = channel_control_one_ff[`OCP_TBSEL_LSB +: 3];
	assign sync_source_select = channel_control_two_ff[`OCP_SYNC_LSB +: 5];
	assign output_tristate = channel_control_two_ff[`OCP_TRIS_BIT];
	assign trigger_mode_select = channel_control_two_ff[`OCP_TRIG_BIT];
	assign cascade_enable = channel_control_two_ff[`OCP_CASC_BIT];

	assign wr_ctrl1 = reg_wr_i && (reg_addr_i == `OCP_ADDR_CTRL1);
	assign wr_ctrl2 = reg_wr_i && (reg_addr_i == `OCP_ADDR_CTRL2);

	assign is_pwm = (output_mode_select == `OCP_MODE_PWM_EDGE) || (output_mode_select == `OCP_MODE_PWM_CTR);
	assign is_high = cascade_enable && CASC_HIGH;

	assign own_step = tb_tick(timebase_select, timer_tick_i);
	assign step = is_high ? casc_step_i : own_step;
	assign cnt_inc = is_high ? casc_carry_i : 1'b1;

	assign casc_step_o = own_step;
	assign casc_pri_match_o = (channel_counter == (is_pwm ? pri_buf_ff : primary_compare_reg_ff));
	assign casc_sec_match_o = (channel_counter == (is_pwm ? sec_buf_ff : secondary_compare_reg_ff));
	assign casc_per_match_o = (channel_counter == timer_period_reg_ff);

	assign pri_hit = step && run && pair_match(casc_pri_match_o, casc_pri_match_i, cascade_enable);
	assign sec_hit = step && run && pair_match(casc_sec_match_o, casc_sec_match_i, cascade_enable);
	assign per_hit = step && run && pair_match(casc_per_match_o, casc_per_match_i, cascade_enable);

	assign sync_ev = (sync_source_select == `OCP_SYNC_SELF) ? per_hit : sync_event_i[sync_source_select];

	assign run = (output_mode_select != `OCP_MODE_OFF)
		&& ((sync_source_select == `OCP_SYNC_FREE) || !trigger_mode_select || trigger_status_ff);

	assign cnt_clr = !run || ((sync_source_select != `OCP_SYNC_FREE) && !trigger_mode_select && sync_ev);

	assign casc_carry_o = step && run && !cnt_clr && (channel_counter == `OCP_CNT_MAX);

	ocp_counter #(
		.W(W)
	) u_counter (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.clr_i(cnt_clr),
		.inc_i(step && run && cnt_inc),
		.count_o(channel_counter)
	);

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			channel_control_one_ff <= `OCP_CTRL1_RST;
			channel_control_two_ff <= `OCP_CTRL2_RST;
			primary_compare_reg_ff <= '0;
			secondary_compare_reg_ff <= '0;
			timer_period_reg_ff <= '0;
		end
		else if (ce_i && reg_wr_i)
		begin
			unique case (reg_addr_i)
				`OCP_ADDR_CTRL1: channel_control_one_ff <= reg_wdata_i & `OCP_CTRL1_WMASK;
				`OCP_ADDR_CTRL2: channel_control_two_ff <= reg_wdata_i & `OCP_CTRL2_WMASK;
				`OCP_ADDR_PRI: primary_compare_reg_ff <= reg_wdata_i[W-1:0];
				`OCP_ADDR_SEC: secondary_compare_reg_ff <= reg_wdata_i[W-1:0];
				`OCP_ADDR_PER: timer_period_reg_ff <= reg_wdata_i[W-1:0];
				default: ;
			endcase
		end
	end

	// duty buffers load at period end in PWM modes, every enabled cycle otherwise
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pri_buf_ff <= '0;
			sec_buf_ff <= '0;
		end
		else if (ce_i && (!is_pwm || per_hit))
		begin
			pri_buf_ff <= primary_compare_reg_ff;
			sec_buf_ff <= secondary_compare_reg_ff;
		end
	end

	// Hardware clear first, software next, trigger event wins
	always_comb
	begin
		nxt_trigger_status = trigger_status_ff;
		if (trigger_status_clear_mode && sec_hit)
			nxt_trigger_status = 1'b0;
		if (wr_ctrl2)
			nxt_trigger_status = reg_wdata_i[`OCP_TRGST_BIT];
		if (trigger_mode_select && (sync_source_select != `OCP_SYNC_FREE) && sync_ev)
			nxt_trigger_status = 1'b1;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			trigger_status_ff <= 1'b0;
		else if (ce_i)
			trigger_status_ff <= nxt_trigger_status;
	end

	// Fault status is sticky; writing zero clears it unless a fault persists
	always_comb
	begin
		nxt_fault_stat = fault_stat_ff;
		if (wr_ctrl1)
			nxt_fault_stat = fault_stat_ff & reg_wdata_i[`OCP_FLTST_LSB +: 3];
		if (is_pwm)
			nxt_fault_stat = nxt_fault_stat | (fault_i & fault_input_enables);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			fault_stat_ff <= 3'h0;
		else if (ce_i)
			fault_stat_ff <= nxt_fault_stat;
	end

	always_comb
	begin
		if (output_mode_select == `OCP_MODE_PWM_CTR)
			pwm_level = (channel_counter >= pri_buf_ff) && (channel_counter < sec_buf_ff);
		else
			pwm_level = channel_counter < sec_buf_ff;
	end

	always_comb
	begin
		nxt_out = out_ff;
		nxt_phase = phase_ff;
		irq_ev = 1'b0;
		if (wr_ctrl1)
		begin
			nxt_phase = (reg_wdata_i[`OCP_MODE_LSB +: 3] == `OCP_MODE_OFF) ? ocp_pkg::OCP_ST_IDLE : ocp_pkg::OCP_ST_ARMED;
			nxt_out = (reg_wdata_i[`OCP_MODE_LSB +: 3] == `OCP_MODE_SS_FALL);
		end
		else if (is_pwm)
		begin
			// Any latched fault parks the pin low
			nxt_out = pwm_level && (fault_stat_ff == 3'h0);
			irq_ev = per_hit;
		end
		else if (phase_ff == ocp_pkg::OCP_ST_ARMED || phase_ff == ocp_pkg::OCP_ST_ACTIVE)
		begin
			unique case (output_mode_select)
				`OCP_MODE_SS_RISE, `OCP_MODE_SS_FALL:
				begin
					if (pri_hit)
					begin
						nxt_out = !out_ff;
						irq_ev = 1'b1;
						nxt_phase = ocp_pkg::OCP_ST_SPENT;
					end
				end
				`OCP_MODE_TOGGLE:
				begin
					if (pri_hit)
					begin
						nxt_out = !out_ff;
						irq_ev = 1'b1;
					end
				end
				`OCP_MODE_DBL_SS, `OCP_MODE_DBL_CONT:
				begin
					if (phase_ff == ocp_pkg::OCP_ST_ARMED && pri_hit)
					begin
						nxt_out = 1'b1;
						nxt_phase = ocp_pkg::OCP_ST_ACTIVE;
					end
					else if (phase_ff == ocp_pkg::OCP_ST_ACTIVE && sec_hit)
					begin
						nxt_out = 1'b0;
						irq_ev = 1'b1;
						nxt_phase = (output_mode_select == `OCP_MODE_DBL_CONT) ? ocp_pkg::OCP_ST_ARMED : ocp_pkg::OCP_ST_SPENT;
					end
				end
				default:
					nxt_phase = ocp_pkg::OCP_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			phase_ff <= ocp_pkg::OCP_ST_IDLE;
			out_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			phase_ff <= nxt_phase;
			out_ff <= nxt_out;
		end
	end

	// sticky flag, set beats write one clear
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			compare_irq_flag_ff <= 1'b0;
		else if (ce_i)
		begin
			if (irq_ev)
				compare_irq_flag_ff <= 1'b1;
			else if (reg_wr_i && reg_addr_i == `OCP_ADDR_STAT && reg_wdata_i[`OCP_IRQ_BIT])
				compare_irq_flag_ff <= 1'b0;
		end
	end

	always_comb
	begin
		nxt_rdata = 16'h0000;
		unique case (reg_addr_i)
			`OCP_ADDR_CTRL1: nxt_rdata = channel_control_one_ff | {9'h000, fault_stat_ff, 4'h0};
			`OCP_ADDR_CTRL2: nxt_rdata = channel_control_two_ff | {9'h000, trigger_status_ff, 6'h00};
			`OCP_ADDR_PRI: nxt_rdata[W-1:0] = primary_compare_reg_ff;
			`OCP_ADDR_SEC: nxt_rdata[W-1:0] = secondary_compare_reg_ff;
			`OCP_ADDR_PER: nxt_rdata[W-1:0] = timer_period_reg_ff;
			`OCP_ADDR_CNT: nxt_rdata[W-1:0] = channel_counter;
			`OCP_ADDR_STAT: nxt_rdata[`OCP_IRQ_BIT] = compare_irq_flag_ff;
			default: nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_ff <= 16'h0000;
		else if (ce_i && reg_rd_i)
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata_o = rdata_ff;
	assign waveform_output_pin_o = out_ff;
	// tristate bit gates low half pin
	assign waveform_oe_n_o = cascade_enable && !CASC_HIGH && output_tristate;
	assign compare_irq_flag_o = compare_irq_flag_ff;
endmodule

// File: ocp_channel_assertions.sv
// Port checker of the output compare channel, bound to the channel
`timescale 1ns/1ps
module ocp_channel_chk (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic casc_pri_match_o,
	input wire logic casc_sec_match_o,
	input wire logic waveform_output_pin_o,
	input wire logic waveform_oe_n_o,
	input wire logic compare_irq_flag_o
);
	logic [2:0] mode_ff;
	logic wr1;
	logic wr6;
	assign wr1 = ce_i && reg_wr_i && reg_addr_i == 3'h0;
	assign wr6 = ce_i && reg_wr_i && reg_addr_i == 3'h6;
	// Shadow of the mode, since the checker cannot see inside
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mode_ff <= 3'h0;
		else if (wr1)
			mode_ff <= reg_wdata_i[2:0];
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	AST_OFF_HOLD: assert property (mode_ff == 3'h0 && !wr1 |=> $stable(waveform_output_pin_o))
		else $error("pin moved while channel off");
	AST_SS_HOLD: assert property (mode_ff == 3'h1 && waveform_output_pin_o && !wr1 |=> waveform_output_pin_o)
		else $error("single shot pulse ended without rearm");
	AST_PRI_RISE: assert property (mode_ff == 3'h1 && $rose(waveform_output_pin_o) && !$past(wr1)
		|-> $past(casc_pri_match_o))
		else $error("pin rose without primary match");
	AST_SEC_FALL: assert property (mode_ff[2:1] == 2'b10 && $fell(waveform_output_pin_o) && !$past(wr1)
		|-> $past(casc_sec_match_o))
		else $error("pin fell without secondary match");
	AST_IRQ_DBL: assert property (mode_ff[2:1] == 2'b10 && $rose(compare_irq_flag_o) && !$past(wr1)
		|-> $past(casc_sec_match_o))
		else $error("double mode flag without secondary match");
	AST_IRQ_SGL: assert property (mode_ff != 3'h0 && !mode_ff[2] && $rose(compare_irq_flag_o) && !$past(wr1)
		|-> $past(casc_pri_match_o))
		else $error("single mode flag without primary match");
	AST_IRQ_STICKY: assert property (compare_irq_flag_o && !wr6 |=> compare_irq_flag_o)
		else $error("flag dropped without clear");
	AST_OE_DRIVE: assert property (ce_i && reg_wr_i && reg_addr_i == 3'h1 && !reg_wdata_i[5]
		|=> !waveform_oe_n_o)
		else $error("pin not driven with tristate cleared");
endmodule
bind ocp_channel ocp_channel_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.casc_pri_match_o(casc_pri_match_o), .casc_sec_match_o(casc_sec_match_o),
	.waveform_output_pin_o(waveform_output_pin_o), .waveform_oe_n_o(waveform_oe_n_o),
	.compare_irq_flag_o(compare_irq_flag_o));

// File: ocp_load.sv
// Load model on the waveform pin: counts rises, high cycles and pulse width
`timescale 1ns/1ps
module ocp_load (
	input wire logic core_clk_i,
	input wire logic clr_i,
	input wire logic pin_i,
	input wire logic oe_n_i,
	output logic [15:0] rises_o,
	output logic [15:0] highs_o,
	output logic [15:0] width_o
);
	logic last_ff;
	logic [15:0] run_ff;
	logic lvl;
	// A released pin is pulled low by the load
	assign lvl = pin_i && !oe_n_i;
	always_ff @(posedge core_clk_i)
	begin
		last_ff <= lvl;
		run_ff <= lvl ? run_ff + 16'h0001 : 16'h0000;
		if (!lvl && last_ff)
			width_o <= run_ff;
		if (clr_i)
		begin
			rises_o <= 16'h0000;
			highs_o <= 16'h0000;
		end
		else
		begin
			rises_o <= rises_o + {15'h0000, lvl && !last_ff};
			highs_o <= highs_o + {15'h0000, lvl};
		end
	end
endmodule

// File: output_compare_pwm_channel_bench.sv
// Self-checking bench of the output compare channel
`timescale 1ns/1ps
module output_compare_pwm_channel_bench;
	logic core_clk, rst_n, ce, wr, rd, clr, pin, oe_n, irq;
	logic [2:0] addr, flt;
	logic [15:0] wdata, rdata, rises, highs, width, v, w;
	logic [4:0] tick, ci;
	logic [31:0] ev;
	int mismatches, compares, n;
	logic [15:0] tbl [4][6] = '{'{16'h1c06, 16'h0000, 16'h0004, 16'h0009, 16'h0028, 16'h000a},
		'{16'h1c07, 16'h0002, 16'h0006, 16'h0009, 16'h0028, 16'h000a},
		'{16'h1c06, 16'h0000, 16'h000c, 16'h0009, 16'h0064, 16'h0000},
		'{16'h1c06, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}};
	ocp_channel u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .timer_tick_i(tick),
		.sync_event_i(ev), .fault_i(flt), .casc_step_i(ci[0]), .casc_carry_i(ci[1]),
		.casc_pri_match_i(ci[2]), .casc_sec_match_i(ci[3]), .casc_per_match_i(ci[4]),
		.casc_step_o(), .casc_carry_o(), .casc_pri_match_o(), .casc_sec_match_o(), .casc_per_match_o(),
		.waveform_output_pin_o(pin), .waveform_oe_n_o(oe_n), .compare_irq_flag_o(irq));
	ocp_load u_load (.core_clk_i(core_clk), .clr_i(clr), .pin_i(pin), .oe_n_i(oe_n),
		.rises_o(rises), .highs_o(highs), .width_o(width));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic pulse(input logic [31:0] e, input logic [4:0] t);
		@(posedge core_clk);
		ev <= e;
		tick <= t;
		@(posedge core_clk);
		ev <= 32'h0000_0000;
		tick <= 5'h00;
	endtask
	// Bounded wait; running out ends the run as a failure
	task automatic wait_pin(input logic l, output int k);
		#1;
		k = 0;
		while (pin !== l && k < 50)
		begin
			@(posedge core_clk);
			#1;
			k++;
		end
		if (k == 50)
		begin
			mismatches++;
			$display("ERROR pin wait expected %b seen %b", l, pin);
			finish_test();
		end
	endtask
	task automatic measure();
		@(posedge core_clk);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		repeat (100) @(posedge core_clk);
		#1;
	endtask
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		{wr, rd, clr, flt, ci, tick, ev} = '0;
		addr = 3'h0;
		wdata = 16'h0000;
		mismatches = 0;
		compares = 0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		rd_reg(3'h0, v);
		chk("ctrl1 reset", 16'h0000, v);
		rd_reg(3'h1, v);
		chk("ctrl2 reset", 16'h000c, v);
		rd_reg(3'h7, v);
		chk("unmapped read", 16'h0000, v);
		$display("reset test done");
		wr_reg(3'h1, 16'h0000);
		wr_reg(3'h0, 16'h1c03);
		rd_reg(3'h5, v);
		rd_reg(3'h5, w);
		chk("free count step", 16'h0002, w - v);
		// Low enable must freeze the counter for the five held edges
		@(posedge core_clk);
		ce <= 1'b0;
		repeat (5) @(posedge core_clk);
		ce <= 1'b1;
		rd_reg(3'h5, v);
		chk("ce freeze", 16'h0003, v - w);
		wr_reg(3'h0, 16'h0003);
		rd_reg(3'h5, v);
		repeat (3) pulse(32'h0000_0000, 5'h01);
		pulse(32'h0000_0000, 5'h02);
		rd_reg(3'h5, w);
		chk("tick count", v + 16'h0003, w);
		wr_reg(3'h0, 16'h1c03);
		wr_reg(3'h1, 16'h0081);
		rd_reg(3'h5, v);
		chk("trigger hold", 16'h0000, v);
		pulse(32'h0000_0002, 5'h00);
		rd_reg(3'h5, v);
		chk("trigger run", 16'h0001, {15'h0000, v != 16'h0000});
		wr_reg(3'h1, 16'h0001);
		pulse(32'h0000_0002, 5'h00);
		rd_reg(3'h5, v);
		chk("sync clear", 16'h0001, v);
		chk("pin driven", 16'h0000, oe_n);
		wr_reg(3'h1, 16'h0120);
		#1;
		chk("pin released", 16'h0001, oe_n);
		wr_reg(3'h1, 16'h0100);
		#1;
		chk("pin forced", 16'h0000, oe_n);
		$display("timebase test done");
		wr_reg(3'h0, 16'h1c00);
		wr_reg(3'h1, 16'h001f);
		wr_reg(3'h2, 16'h0003);
		wr_reg(3'h4, 16'h0009);
		wr_reg(3'h6, 16'h0001);
		wr_reg(3'h0, 16'h1c01);
		wait_pin(1'b1, n);
		chk("rise delay", 16'h0004, n[15:0]);
		chk("single flag", 16'h0001, irq);
		wr_reg(3'h6, 16'h0001);
		repeat (30) @(posedge core_clk);
		#1;
		chk("one shot only", 16'h0000, irq);
		wr_reg(3'h0, 16'h1c01);
		#1;
		chk("rearm default", 16'h0000, pin);
		wait_pin(1'b1, n);
		chk("rearm flag", 16'h0001, irq);
		wr_reg(3'h0, 16'h1c02);
		#1;
		chk("high default", 16'h0001, pin);
		wait_pin(1'b0, n);
		$display("single shot test done");
		wr_reg(3'h0, 16'h1c00);
		wr_reg(3'h6, 16'h0001);
		wr_reg(3'h3, 16'h0005);
		wr_reg(3'h2, 16'h0002);
		wr_reg(3'h0, 16'h1c05);
		measure();
		chk("pulse count", 16'h000a, rises);
		chk("pulse width", 16'h0003, width);
		chk("double flag", 16'h0001, irq);
		$display("double compare test done");
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(3'h0, 16'h1c00);
			wr_reg(3'h2, tbl[i][1]);
			wr_reg(3'h3, tbl[i][2]);
			wr_reg(3'h4, tbl[i][3]);
			wr_reg(3'h0, tbl[i][0]);
			repeat (40) @(posedge core_clk);
			measure();
			chk("pwm high cycles", tbl[i][4], highs);
			chk("pwm periods", tbl[i][5], rises);
		end
		// Full duty first, so a latched fault visibly parks the pin
		wr_reg(3'h3, 16'h000c);
		wr_reg(3'h4, 16'h0009);
		wr_reg(3'h0, 16'h1c86);
		repeat (20) @(posedge core_clk);
		#1;
		chk("fault free level", 16'h0001, pin);
		@(posedge core_clk);
		flt <= 3'h1;
		@(posedge core_clk);
		flt <= 3'h0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("fault park", 16'h0000, pin);
		rd_reg(3'h0, v);
		chk("fault status", 16'h1c96, v);
		$display("pwm test done");
		finish_test();
	end
endmodule
